// [pll_clock_generator_control.sv]
// Summary of operation
// RULE_01: Base clock is selected source halved
// RULE_02: Crystal runs only with oscillator enable
// RULE_03: Reference clocks copy the crystal clock
// RULE_04: VCO divided modulo N gives feedback
// RULE_05: VCO center is L times nominal
// RULE_06: Phase detector drives direction-and-width pulses
// RULE_07: Lock detector compares feedback and reference frequency
// RULE_08: Acquisition shown by tracking bit zero
// RULE_09: Tracking whenever not acquiring or bit set
// RULE_10: Auto mode: detector switches filter mode
// RULE_11: Auto: tracking bit read-only, hysteresis tolerances
// RULE_12: Auto: lock flag set/cleared with hysteresis
// RULE_13: Auto: interrupt request on each lock toggle
// RULE_14: Software recovers if unlocked on VCO
// RULE_15: Manual: tracking bit writable, sets mode
// RULE_16: Manual: software clears tracking before power-on
// RULE_17: Manual: software waits acquisition time first
// RULE_18: Manual: software waits before selecting VCO
// RULE_19: Manual: lock flag and interrupts disabled
// RULE_20: Base clock held three edges each source; code releases after seven crystal edges even without three VCO edges
// RULE_21: Refuse VCO while off, off while selected
// RULE_22: L zero disables PLL, forces crystal
// RULE_23: N zero behaves as N one
// RULE_24: Three byte registers at consecutive addresses
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "pll_clock_defs.svh"

module pll_clock_generator_control #(
    parameter logic [7:0] LOCK_WINDOW = `LOCK_WINDOW,
    parameter logic [8:0] TOL_TRACK = `TOL_TRACK,
    parameter logic [8:0] TOL_UNTRACK = `TOL_UNTRACK,
    parameter logic [8:0] TOL_LOCK = `TOL_LOCK,
    parameter logic [8:0] TOL_UNLOCK = `TOL_UNLOCK
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire pll_clock_pkg::reg_req_s bus_req,
    output logic [7:0] read_data,
    // Oscillator
    input wire logic oscillator_enable_signal,
    input wire logic oscillator_input_pin,
    output logic oscillator_output_pin,
    // VCO interface
    input wire logic vco_clock,
    output logic pll_enable,
    output logic [3:0] vco_range,
    output logic [26:0] vco_center_hz,
    output logic [26:0] vco_min_hz,
    output logic [26:0] vco_max_hz,
    output logic filter_tracking,
    output logic pump_up,
    output logic pump_down,
    // Generated clocks
    output logic crystal_clock,
    output logic pll_reference_clock,
    output logic final_reference_clock,
    output logic vco_feedback_clock,
    output logic base_clock_out,
    // Interrupt request to the CPU
    output logic pll_interrupt_request
);
    import pll_clock_pkg::*;

    logic [1:0] rst_sync;
    logic reset_n;
    logic [1:0] clk_level;
    logic [1:0] clk_rise;
    cgm_state_s state;
    cgm_state_s next_state;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign reset_n = rst_sync[1];

    // Both source clocks are foreign to this domain
    clock_edge_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({vco_clock, oscillator_input_pin}),
        .level(clk_level),
        .rise(clk_rise)
    );

    function automatic logic [8:0] abs_diff(input logic [8:0] a, input logic [8:0] b);
        abs_diff = (a > b) ? 9'(a - b) : 9'(b - a);
    endfunction

    always_comb begin
        logic l_zero;
        logic [3:0] n_eff;
        logic pll_run;
        logic select_vco;
        logic xtal_edge;
        logic vco_edge;
        logic src_edge;
        logic fb_edge;
        logic win_end;
        logic [8:0] fb_total;
        logic [8:0] diff;
        logic wr_ctl;
        logic wr_bw;
        logic wr_prog;
        logic req_on;
        logic req_sel;
        logic lock_toggle;
        next_state = state;
        l_zero = (state.prog.range_l == 4'h0);
        n_eff = (state.prog.mult_n == 4'h0) ? 4'h1 : state.prog.mult_n; // RULE_23
        pll_run = state.ctl.power_on & ~l_zero & oscillator_enable_signal; // RULE_22
        select_vco = state.ctl.base_select & ~l_zero; // RULE_22
        xtal_edge = clk_rise[0] & oscillator_enable_signal; // RULE_02
        vco_edge = clk_rise[1] & pll_run;
        src_edge = state.active_vco ? vco_edge : xtal_edge;
        fb_edge = 1'b0;
        win_end = 1'b0;
        fb_total = 9'h000;
        diff = 9'h000;
        lock_toggle = 1'b0;
        wr_ctl = bus_req.write && (bus_req.addr == `ADDR_PLL_CONTROL); // RULE_24
        wr_bw = bus_req.write && (bus_req.addr == `ADDR_PLL_BANDWIDTH_CONTROL);
        wr_prog = bus_req.write && (bus_req.addr == `ADDR_PLL_MULTIPLIER_PROGRAM);
        req_on = bus_req.wdata[`CTL_POWER_ON_BIT];
        req_sel = bus_req.wdata[`CTL_BASE_SELECT_BIT];

        // Oscillator and reference path
        next_state.xtal_clk = clk_level[0] & oscillator_enable_signal; // RULE_02
        next_state.osc_out = ~clk_level[0] & oscillator_enable_signal; // RULE_02
        next_state.ref_clk = next_state.xtal_clk; // RULE_03
        next_state.center_hz = 27'(state.prog.range_l) * `NOM_CENTER_HZ; // RULE_05

        // Modulo-N feedback divider, one pulse per N VCO edges
        next_state.fb_clk = 1'b0;
        if (!pll_run) begin
            next_state.div_cnt = 4'h0;
        end else if (vco_edge) begin
            if (state.div_cnt >= 4'(n_eff - 4'h1)) begin // RULE_04
                next_state.div_cnt = 4'h0;
                next_state.fb_clk = 1'b1;
                fb_edge = 1'b1;
            end else begin
                next_state.div_cnt = 4'(state.div_cnt + 4'h1);
            end
        end

        // Phase detector: the leading edge opens a pulse, the lagging one closes it
        if (!pll_run) begin
            next_state.pump_up = 1'b0;
            next_state.pump_down = 1'b0;
        end else if (xtal_edge && fb_edge) begin
            next_state.pump_up = 1'b0; // RULE_06
            next_state.pump_down = 1'b0;
        end else if (xtal_edge) begin
            next_state.pump_up = ~state.pump_down; // RULE_06
            next_state.pump_down = 1'b0;
        end else if (fb_edge) begin
            next_state.pump_down = ~state.pump_up; // RULE_06
            next_state.pump_up = 1'b0;
        end

        // Lock detector: feedback edges counted over a window of reference edges
        if (!pll_run) begin
            next_state.win_cnt = 8'h00;
            next_state.fb_cnt = 9'h000;
        end else begin
            fb_total = 9'(state.fb_cnt + {8'h00, fb_edge});
            if (xtal_edge && state.win_cnt >= 8'(LOCK_WINDOW - 8'h01)) begin
                win_end = 1'b1;
                diff = abs_diff(fb_total, {1'b0, LOCK_WINDOW}); // RULE_07
                next_state.win_cnt = 8'h00;
                next_state.fb_cnt = 9'h000;
            end else begin
                next_state.win_cnt = 8'(state.win_cnt + {7'h00, xtal_edge});
                next_state.fb_cnt = fb_total;
            end
        end

        if (state.bw.auto_mode) begin
            if (!pll_run) begin
                next_state.bw.tracking = 1'b0; // RULE_08
                next_state.bw.lock = 1'b0;
            end else if (win_end) begin
                if (diff <= TOL_TRACK) begin
                    next_state.bw.tracking = 1'b1; // RULE_10 RULE_11
                end else if (diff > TOL_UNTRACK) begin
                    next_state.bw.tracking = 1'b0; // RULE_11
                end
                if (diff <= TOL_LOCK) begin
                    next_state.bw.lock = 1'b1; // RULE_12
                end else if (diff > TOL_UNLOCK) begin
                    next_state.bw.lock = 1'b0; // RULE_12
                end
            end
            lock_toggle = (next_state.bw.lock != state.bw.lock);
        end else begin
            next_state.bw.lock = 1'b0; // RULE_19
        end

        // Register writes
        if (wr_ctl) begin
            next_state.ctl.irq_enable = bus_req.wdata[`CTL_IRQ_ENABLE_BIT];
            // Power and selection may not change in the same write
            if (!((req_on != state.ctl.power_on) && (req_sel != state.ctl.base_select))) begin
                if (req_on || !state.ctl.base_select) begin // RULE_21
                    next_state.ctl.power_on = req_on;
                end
                if (!req_sel || (state.ctl.power_on && !l_zero)) begin // RULE_21 RULE_22
                    next_state.ctl.base_select = req_sel;
                end
            end
        end
        if (wr_bw) begin
            next_state.bw.auto_mode = bus_req.wdata[`BW_AUTO_BIT];
            if (!bus_req.wdata[`BW_AUTO_BIT]) begin
                next_state.bw.tracking = bus_req.wdata[`BW_TRACKING_BIT]; // RULE_15
                next_state.bw.lock = 1'b0; // RULE_19
            end
        end
        if (wr_prog) begin
            next_state.prog.mult_n = bus_req.wdata[`PROG_N_MSB:`PROG_N_LSB];
            next_state.prog.range_l = bus_req.wdata[`PROG_L_MSB:`PROG_L_LSB];
        end
        if (next_state.prog.range_l == 4'h0) begin
            next_state.ctl.base_select = 1'b0; // RULE_22
        end

        // Pending lock change: set wins over the clearing read
        if (!state.bw.auto_mode) begin
            next_state.lock_pending = 1'b0; // RULE_19
        end else if (lock_toggle) begin
            next_state.lock_pending = 1'b1; // RULE_13
        end else if (bus_req.read && bus_req.addr == `ADDR_PLL_CONTROL) begin
            next_state.lock_pending = 1'b0;
        end

        // Base clock selector with changeover hold
        unique case (state.sel_state)
            SEL_RUN: begin
                if (select_vco != state.active_vco) begin
                    next_state.sel_state = SEL_HOLD; // RULE_20
                    next_state.hold_x = 3'h0;
                    next_state.hold_v = 2'h0;
                end else if (src_edge) begin
                    next_state.base_clk = ~state.base_clk; // RULE_01
                end
            end
            SEL_HOLD: begin
                if (xtal_edge && state.hold_x != `HOLD_X_LIMIT) begin
                    next_state.hold_x = 3'(state.hold_x + 3'h1);
                end
                if (vco_edge && state.hold_v != `HOLD_EDGES) begin
                    next_state.hold_v = 2'(state.hold_v + 2'h1);
                end
                // A stalled VCO cannot keep the crystal waiting forever
                if ((state.hold_x >= 3'({1'b0, `HOLD_EDGES}) && state.hold_v == `HOLD_EDGES)
                    || state.hold_x == `HOLD_X_LIMIT) begin // RULE_20
                    next_state.sel_state = SEL_RUN;
                    next_state.active_vco = select_vco;
                end
            end
        endcase

        // Read data, one cycle after the strobe
        next_state.rdata = 8'h00;
        if (bus_req.read) begin
            unique case (bus_req.addr)
                `ADDR_PLL_CONTROL: begin
                    next_state.rdata[`CTL_IRQ_ENABLE_BIT] = state.ctl.irq_enable;
                    next_state.rdata[`CTL_LOCK_PENDING_BIT] = state.lock_pending;
                    next_state.rdata[`CTL_POWER_ON_BIT] = state.ctl.power_on;
                    next_state.rdata[`CTL_BASE_SELECT_BIT] = state.ctl.base_select;
                end
                `ADDR_PLL_BANDWIDTH_CONTROL: begin
                    next_state.rdata[`BW_AUTO_BIT] = state.bw.auto_mode;
                    next_state.rdata[`BW_LOCK_BIT] = state.bw.lock;
                    next_state.rdata[`BW_TRACKING_BIT] = state.bw.tracking; // RULE_08
                end
                `ADDR_PLL_MULTIPLIER_PROGRAM: begin
                    next_state.rdata = {state.prog.mult_n, state.prog.range_l};
                end
                default: begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
            state.ctl.irq_enable <= 1'b0;
            state.prog <= `RESET_PLL_MULTIPLIER_PROGRAM;
        end else begin
            state <= next_state;
        end
    end

    assign read_data = state.rdata;
    assign oscillator_output_pin = state.osc_out;
    assign pll_enable = state.ctl.power_on & (state.prog.range_l != 4'h0)
        & oscillator_enable_signal; // RULE_22
    assign vco_range = state.prog.range_l;
    assign vco_center_hz = state.center_hz; // RULE_05
    assign vco_min_hz = {1'b0, state.center_hz[26:1]}; // RULE_05
    assign vco_max_hz = {state.center_hz[25:0], 1'b0}; // RULE_05
    // Filter tracks unless held in acquisition by a clear tracking bit
    assign filter_tracking = state.bw.tracking; // RULE_09
    assign pump_up = state.pump_up;
    assign pump_down = state.pump_down;
    assign crystal_clock = state.xtal_clk;
    assign pll_reference_clock = state.ref_clk; // RULE_03
    assign final_reference_clock = state.ref_clk; // RULE_03
    assign vco_feedback_clock = state.fb_clk;
    assign base_clock_out = state.base_clk;
    assign pll_interrupt_request = state.lock_pending & state.ctl.irq_enable
        & state.bw.auto_mode; // RULE_13 RULE_19
endmodule // pll_clock_generator_control

// [pll_clock_defs.svh]
`ifndef PLL_CLOCK_DEFS_SVH
`define PLL_CLOCK_DEFS_SVH

// Byte addresses of the three registers
`define ADDR_PLL_CONTROL 8'h1c
`define ADDR_PLL_BANDWIDTH_CONTROL 8'h1d
`define ADDR_PLL_MULTIPLIER_PROGRAM 8'h1e

// pll_control fields
`define CTL_IRQ_ENABLE_BIT 7
`define CTL_LOCK_PENDING_BIT 6
`define CTL_POWER_ON_BIT 5
`define CTL_BASE_SELECT_BIT 4

// pll_bandwidth_control fields
`define BW_AUTO_BIT 7
`define BW_LOCK_BIT 6
`define BW_TRACKING_BIT 5

// pll_multiplier_program fields
`define PROG_N_MSB 7
`define PROG_N_LSB 4
`define PROG_L_MSB 3
`define PROG_L_LSB 0

// Reset values
`define RESET_PLL_CONTROL 8'h00
`define RESET_PLL_BANDWIDTH_CONTROL 8'h00
`define RESET_PLL_MULTIPLIER_PROGRAM 8'h66

// Nominal VCO center frequency in Hz (4.9152 MHz)
`define NOM_CENTER_HZ 27'h4b_0000

// Base clock changeover: edges of each source to wait, and safety limit
`define HOLD_EDGES 2'h3
`define HOLD_X_LIMIT 3'h7

// Lock detector defaults: window in reference edges, tolerances in feedback edges
`define LOCK_WINDOW 8'h40
`define TOL_TRACK 9'h002
`define TOL_UNTRACK 9'h004
`define TOL_LOCK 9'h001
`define TOL_UNLOCK 9'h003

`endif

// [pll_clock_pkg.sv]
package pll_clock_pkg;

typedef enum logic [0:0] {
    SEL_RUN = 1'b0,
    SEL_HOLD = 1'b1
} sel_state_e;

typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
} reg_req_s;

typedef struct packed {
    logic irq_enable;
    logic power_on;
    logic base_select;
} control_s;

typedef struct packed {
    logic auto_mode;
    logic lock;
    logic tracking;
} bandwidth_s;

typedef struct packed {
    logic [3:0] mult_n;
    logic [3:0] range_l;
} program_s;

typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic [1:0] last;
} sync_state_s;

typedef struct packed {
    control_s ctl;
    bandwidth_s bw;
    program_s prog;
    logic lock_pending;
    sel_state_e sel_state;
    logic active_vco;
    logic [2:0] hold_x;
    logic [1:0] hold_v;
    logic base_clk;
    logic [3:0] div_cnt;
    logic fb_clk;
    logic ref_clk;
    logic xtal_clk;
    logic osc_out;
    logic pump_up;
    logic pump_down;
    logic [7:0] win_cnt;
    logic [8:0] fb_cnt;
    logic [26:0] center_hz;
    logic [7:0] rdata;
} cgm_state_s;

endpackage

// [clock_edge_sync.sv]
`timescale 1ns/1ps
`include "pll_clock_defs.svh"

module clock_edge_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Asynchronous inputs
    input wire logic [1:0] async_in,
    // Synchronised levels and rising-edge pulses
    output logic [1:0] level,
    output logic [1:0] rise
);
    import pll_clock_pkg::*;

    sync_state_s state;
    sync_state_s next_state;

    // The meta stage feeds only the stable stage
    always_comb begin
        next_state = state;
        next_state.meta = async_in;
        next_state.stable = state.meta;
        next_state.last = state.stable;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.stable;
    assign rise = state.stable & ~state.last;
endmodule // clock_edge_sync

// [pll_cgc_checker_sva.sv]
`timescale 1ns/1ps
`include "pll_clock_defs.svh"

module pll_cgc_checker #(
    parameter logic [7:0] LOCK_WINDOW = `LOCK_WINDOW,
    parameter logic [8:0] TOL_TRACK = `TOL_TRACK,
    parameter logic [8:0] TOL_UNTRACK = `TOL_UNTRACK,
    parameter logic [8:0] TOL_LOCK = `TOL_LOCK,
    parameter logic [8:0] TOL_UNLOCK = `TOL_UNLOCK
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire pll_clock_pkg::reg_req_s bus_req,
    input wire logic [7:0] read_data,
    // Oscillator
    input wire logic oscillator_enable_signal,
    input wire logic oscillator_input_pin,
    input wire logic oscillator_output_pin,
    // VCO interface
    input wire logic vco_clock,
    input wire logic pll_enable,
    input wire logic [3:0] vco_range,
    input wire logic [26:0] vco_center_hz,
    input wire logic [26:0] vco_min_hz,
    input wire logic [26:0] vco_max_hz,
    input wire logic filter_tracking,
    input wire logic pump_up,
    input wire logic pump_down,
    // Generated clocks and interrupt
    input wire logic crystal_clock,
    input wire logic pll_reference_clock,
    input wire logic final_reference_clock,
    input wire logic vco_feedback_clock,
    input wire logic base_clock_out,
    input wire logic pll_interrupt_request
);
    import pll_clock_pkg::*;

    // Internal reset trails rst_n by two flops, so give outputs time to settle
    logic [2:0] up_cnt;
    logic ready;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt <= 3'h0;
        end else if (up_cnt != 3'h7) begin
            up_cnt <= up_cnt + 3'h1;
        end
    end
    assign ready = (up_cnt == 3'h7);

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence pins_quiet;
        ($stable(oscillator_input_pin) && $stable(vco_clock))[*6];
    endsequence

    sequence pll_held_off;
        (!pll_enable)[*6];
    endsequence

    a_base_needs_edge: assert property ((ready and pins_quiet) |-> $stable(base_clock_out))
        else $error("base clock moved without a source edge");
    a_osc_gated: assert property (!oscillator_enable_signal |=> !crystal_clock && !oscillator_output_pin)
        else $error("crystal path active while oscillator disabled");
    a_ref_copy: assert property (ready |-> pll_reference_clock == crystal_clock
        && final_reference_clock == crystal_clock)
        else $error("reference clocks do not follow crystal clock");
    a_fb_one_cycle: assert property (vco_feedback_clock |=> !vco_feedback_clock)
        else $error("feedback pulse wider than one cycle");
    a_center_scale: assert property (ready && $stable(vco_range)
        |-> vco_center_hz == 27'(vco_range) * `NOM_CENTER_HZ)
        else $error("vco center not range times nominal");
    a_range_bounds: assert property (ready && $stable(vco_center_hz)
        |-> vco_min_hz == (vco_center_hz >> 1) && vco_max_hz == (vco_center_hz << 1))
        else $error("vco bounds not half and twice center");
    a_pump_exclusive: assert property (!(pump_up && pump_down))
        else $error("both correction directions active");
    a_track_readback: assert property ($past(bus_req.read)
        && $past(bus_req.addr) == `ADDR_PLL_BANDWIDTH_CONTROL
        |-> read_data[`BW_TRACKING_BIT] == $past(filter_tracking))
        else $error("tracking bit disagrees with filter mode");
    a_pll_gate: assert property (pll_enable |-> oscillator_enable_signal && vco_range != 4'h0)
        else $error("pll enabled with zero range or oscillator off");
    a_off_no_fb: assert property (pll_held_off |-> !vco_feedback_clock)
        else $error("feedback pulse while pll disabled");
    a_read_idle: assert property (!$past(bus_req.read) |-> read_data == 8'h00)
        else $error("read data outside read answer cycle");
endmodule // pll_cgc_checker

// [test_pll_clock_generator_control.sv]
`timescale 1ns/1ps
`include "pll_clock_defs.svh"

`define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

module test_pll_clock_generator_control;
    import pll_clock_pkg::*;

    logic clock, rst_n, oscillator_enable_signal, oscillator_input_pin, vco_clock;
    reg_req_s bus_req;
    logic [7:0] read_data;
    logic [3:0] vco_range;
    logic [26:0] vco_center_hz;
    logic pll_enable, filter_tracking, crystal_clock, vco_feedback_clock;
    logic base_clock_out, pll_interrupt_request, prev_base;
    int err_total, n_compared, n_base, n_fb;

    pll_clock_generator_control #(.LOCK_WINDOW(8'h08)) pll_clock_generator_control_inst (
        .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .read_data(read_data),
        .oscillator_enable_signal(oscillator_enable_signal),
        .oscillator_input_pin(oscillator_input_pin), .oscillator_output_pin(),
        .vco_clock(vco_clock), .pll_enable(pll_enable), .vco_range(vco_range),
        .vco_center_hz(vco_center_hz), .vco_min_hz(), .vco_max_hz(),
        .filter_tracking(filter_tracking), .pump_up(), .pump_down(),
        .crystal_clock(crystal_clock), .pll_reference_clock(), .final_reference_clock(),
        .vco_feedback_clock(vco_feedback_clock), .base_clock_out(base_clock_out),
        .pll_interrupt_request(pll_interrupt_request)
    );

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        if (base_clock_out !== prev_base) n_base++;
        prev_base = base_clock_out;
        if (vco_feedback_clock === 1'b1) n_fb++;
    end

    task automatic tally_and_finish;
        $display("errors %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus_req.write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        bus_req.read <= 1'b0;
        #1;
        `CHK(read_data, e)
    endtask

    // Slow pulses on the pins so every edge survives the synchronisers
    task automatic edges(input int n, input logic xt, input logic vc);
        repeat (n) begin
            @(posedge clock);
            oscillator_input_pin <= xt;
            vco_clock <= vc;
            repeat (4) @(posedge clock);
            oscillator_input_pin <= 1'b0;
            vco_clock <= 1'b0;
            repeat (3) @(posedge clock);
        end
        repeat (8) @(posedge clock);
        #1;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        oscillator_enable_signal = 1'b1;
        oscillator_input_pin = 1'b0;
        vco_clock = 1'b0;
        prev_base = 1'b0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        rd(`ADDR_PLL_CONTROL, 8'h00);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h00);
        rd(`ADDR_PLL_MULTIPLIER_PROGRAM, 8'h66);
        rd(8'h1f, 8'h00);
        `CHK(vco_range, 4'h6)
        wr(`ADDR_PLL_MULTIPLIER_PROGRAM, 8'h07);
        repeat (2) @(posedge clock);
        #1;
        `CHK(vco_center_hz, 27'h7 * `NOM_CENTER_HZ)
        // Power and select changed together, then select while off
        wr(`ADDR_PLL_CONTROL, 8'h30);
        rd(`ADDR_PLL_CONTROL, 8'h00);
        wr(`ADDR_PLL_CONTROL, 8'h10);
        rd(`ADDR_PLL_CONTROL, 8'h00);
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h00);
        wr(`ADDR_PLL_CONTROL, 8'h20);
        rd(`ADDR_PLL_CONTROL, 8'h20);
        `CHK(pll_enable, 1'b1)
        n_fb = 0;
        edges(6, 1'b0, 1'b1);
        `CHK(n_fb, 6)
        wr(`ADDR_PLL_MULTIPLIER_PROGRAM, 8'h37);
        n_fb = 0;
        edges(12, 1'b0, 1'b1);
        `CHK(n_fb, 4)
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h20);
        n_base = 0;
        edges(5, 1'b1, 1'b0);
        `CHK(n_base, 5)
        // Changeover to VCO with the VCO silent: output must freeze
        wr(`ADDR_PLL_CONTROL, 8'h30);
        rd(`ADDR_PLL_CONTROL, 8'h30);
        n_base = 0;
        edges(5, 1'b1, 1'b0);
        `CHK(n_base, 0)
        edges(4, 1'b1, 1'b1);
        `CHK(n_base inside {[1:4]}, 1'b1)
        wr(`ADDR_PLL_CONTROL, 8'h10);
        rd(`ADDR_PLL_CONTROL, 8'h30);
        wr(`ADDR_PLL_MULTIPLIER_PROGRAM, 8'h30);
        rd(`ADDR_PLL_CONTROL, 8'h20);
        `CHK(pll_enable, 1'b0)
        n_fb = 0;
        edges(3, 1'b0, 1'b1);
        `CHK(n_fb, 0)
        // Manual bandwidth mode
        wr(`ADDR_PLL_MULTIPLIER_PROGRAM, 8'h17);
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h20);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h20);
        `CHK(filter_tracking, 1'b1)
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h00);
        #1;
        `CHK(filter_tracking, 1'b0)
        wr(`ADDR_PLL_CONTROL, 8'ha0);
        edges(24, 1'b1, 1'b1);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h00);
        `CHK(pll_interrupt_request, 1'b0)
        // Automatic mode: matched clocks lock, silent VCO unlocks
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h80);
        edges(24, 1'b1, 1'b1);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'he0);
        `CHK(pll_interrupt_request, 1'b1)
        rd(`ADDR_PLL_CONTROL, 8'he0);
        `CHK(pll_interrupt_request, 1'b0)
        wr(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h80);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'he0);
        edges(24, 1'b1, 1'b0);
        rd(`ADDR_PLL_BANDWIDTH_CONTROL, 8'h80);
        `CHK(filter_tracking, 1'b0)
        `CHK(pll_interrupt_request, 1'b1)
        // Oscillator disabled: no crystal edges reach the base clock
        @(posedge clock);
        oscillator_enable_signal <= 1'b0;
        n_base = 0;
        edges(3, 1'b1, 1'b0);
        `CHK(n_base, 0)
        `CHK(pll_enable, 1'b0)
        tally_and_finish();
    end
endmodule // test_pll_clock_generator_control

bind pll_clock_generator_control pll_cgc_checker #(
    .LOCK_WINDOW(LOCK_WINDOW), .TOL_TRACK(TOL_TRACK), .TOL_UNTRACK(TOL_UNTRACK),
    .TOL_LOCK(TOL_LOCK), .TOL_UNLOCK(TOL_UNLOCK)
) pll_cgc_checker_inst (
    .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .read_data(read_data),
    .oscillator_enable_signal(oscillator_enable_signal),
    .oscillator_input_pin(oscillator_input_pin), .oscillator_output_pin(oscillator_output_pin),
    .vco_clock(vco_clock), .pll_enable(pll_enable), .vco_range(vco_range),
    .vco_center_hz(vco_center_hz), .vco_min_hz(vco_min_hz), .vco_max_hz(vco_max_hz),
    .filter_tracking(filter_tracking), .pump_up(pump_up), .pump_down(pump_down),
    .crystal_clock(crystal_clock), .pll_reference_clock(pll_reference_clock),
    .final_reference_clock(final_reference_clock), .vco_feedback_clock(vco_feedback_clock),
    .base_clock_out(base_clock_out), .pll_interrupt_request(pll_interrupt_request)
);
